// ### logic/swa_pkg.sv
// Constants, types and command codes of the single-wire slave.
// Assumes a 125 MHz core clock; pulse times are counted in its cycles.
`default_nettype none
package swa_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS        = 8;
  localparam int unsigned RESET_DETECT_NS      = 480000;
  localparam int unsigned PRESENCE_HIGH_NS     = 30000;
  localparam int unsigned PRESENCE_LOW_NS      = 120000;
  localparam int unsigned SAMPLE_POINT_NS      = 30000;
  localparam int unsigned READ_HOLD_NS         = 45000;
  typedef logic [16:0] swa_cnt_t;
  // Least times round up, the read hold is a longest time and rounds down
  localparam swa_cnt_t RST_CYC = swa_cnt_t'((RESET_DETECT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam swa_cnt_t PDH_CYC = swa_cnt_t'((PRESENCE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam swa_cnt_t PDL_CYC = swa_cnt_t'((PRESENCE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam swa_cnt_t SMP_CYC = swa_cnt_t'((SAMPLE_POINT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam swa_cnt_t RDH_CYC = swa_cnt_t'(READ_HOLD_NS / CLK_PERIOD_NS);
  // ----------------------------------------------------------------
  // Codes and sizes
  // ----------------------------------------------------------------
  localparam logic [7:0] NET_READ      = 8'h33;
  localparam logic [7:0] NET_MATCH     = 8'h55;
  localparam logic [7:0] NET_SKIP      = 8'hCC;
  localparam logic [7:0] CMD_WR_CHAL   = 8'h0C;
  localparam logic [7:0] CMD_HASH_NOID = 8'h36;
  localparam logic [7:0] CMD_HASH_ID   = 8'h35;
  localparam logic [7:0] CMD_CLR_SEC   = 8'h5A;
  localparam logic [7:0] CMD_NXT_NOID  = 8'h30;
  localparam logic [7:0] CMD_NXT_ID    = 8'h33;
  localparam logic [7:0] CMD_LOCK_SEC  = 8'h60;
  localparam logic [7:0] CMD_READ      = 8'h69;
  localparam logic [7:0] CMD_WRITE     = 8'h6C;
  localparam logic [7:0] CMD_COPY      = 8'h48;
  localparam logic [7:0] CMD_RECALL    = 8'hB8;
  localparam logic [7:0] CMD_BLK_LOCK  = 8'h6A;
  localparam logic [7:0] CMD_SOFT_POR  = 8'hBB;
  localparam logic [7:0] LOCK_CTRL_ADDR = 8'h1F;
  localparam int unsigned LOCK_EN_BIT  = 6;
  localparam int unsigned HASH_BITS    = 160;
  localparam logic [7:0] LAST_ID_BIT   = 8'h3F;
  localparam logic [7:0] LAST_HASH_BIT = 8'h9F;
  // Arbitrary identifier value
  localparam logic [63:0] UID_DEFAULT  = 64'h5A5A_0000_0000_0001;
  typedef enum logic [2:0] {L_IDLE, L_SLOT, L_RST, L_PWAIT, L_PLOW} swa_link_t;
  typedef enum logic [3:0] {
    P_WAITRST, P_ROMCMD, P_MATCH, P_ROMRD, P_FCMD, P_ADDR,
    P_RDDATA, P_WRDATA, P_CHAL, P_MACRD
  } swa_phase_t;
endpackage : swa_pkg
`default_nettype wire

// ### logic/swa_slave.sv
// Single-wire bus slave: slot timing, net addressing, function commands.
// Assumes a pulled-up open-drain line, same-clock memory and hash core.
`timescale 1ns/10ps
`default_nettype none
module swa_slave #(
  parameter logic [63:0]       UNIQUE_ID = swa_pkg::UID_DEFAULT,
  parameter swa_pkg::swa_cnt_t RST_CYC   = swa_pkg::RST_CYC,
  parameter swa_pkg::swa_cnt_t PDH_CYC   = swa_pkg::PDH_CYC,
  parameter swa_pkg::swa_cnt_t PDL_CYC   = swa_pkg::PDL_CYC,
  parameter swa_pkg::swa_cnt_t SMP_CYC   = swa_pkg::SMP_CYC,
  parameter swa_pkg::swa_cnt_t RDH_CYC   = swa_pkg::RDH_CYC
) (
  input  wire logic          clk,
  input  wire logic          arst_n,
  input  wire logic          dq_i,
  output logic               dq_o,
  output logic               dq_oe,
  output logic [7:0]         mem_raddr,
  input  wire logic [7:0]    mem_rdata,
  output logic [7:0]         mem_waddr,
  output logic [7:0]         mem_wdata,
  output logic               mem_we,
  output logic [63:0]        challenge,
  output logic               hash_req,
  output logic               hash_use_id,
  input  wire logic [159:0]  hash_result,
  output logic               secret_next_req,
  output logic               secret_clear,
  output logic               secret_locked,
  output logic               blk_copy_req,
  output logic               blk_recall_req,
  output logic               blk_lock_req,
  output logic [7:0]         blk_addr,
  output logic               soft_por_req
);
  import swa_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        s1;
    logic        s2;
    logic        prv;
    swa_link_t   lst;
    swa_cnt_t    cnt;
    logic        drv;
    swa_phase_t  phase;
    logic [7:0]  cmd;
    logic [7:0]  sh;
    logic [7:0]  idx;
    logic [7:0]  addr;
    logic [7:0]  waddr;
    logic [7:0]  wdata;
    logic        we;
    logic [63:0] chal;
    logic        chal_ok;
    logic        lock;
    logic        armed;
    logic        hreq;
    logic        use_id;
    logic        nreq;
    logic        creq;
    logic        cpy;
    logic        rcl;
    logic        blk;
    logic [7:0]  baddr;
    logic        por;
  } swa_state_t;

  swa_state_t q;
  swa_state_t d;
  logic       fall;
  logic       evt;
  logic       tx;
  logic       txbit;
  logic       bdone;
  logic [7:0] nsh;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d     = q;
    evt   = 1'b0;
    fall  = q.prv & ~q.s2;
    nsh   = {q.s2, q.sh[7:1]};
    bdone = (q.idx[2:0] == 3'h7);
    tx    = (q.phase == P_ROMRD) || (q.phase == P_RDDATA) || (q.phase == P_MACRD);
    case (q.phase)
      P_ROMRD:  txbit = UNIQUE_ID[q.idx[5:0]];
      P_RDDATA: txbit = mem_rdata[q.idx[2:0]];
      P_MACRD:  txbit = hash_result[q.idx];
      default:  txbit = 1'b1;
    endcase
    // First stage feeds only the second
    d.s1     = dq_i;
    d.s2     = q.s1;
    d.prv    = q.s2;
    d.we     = 1'b0;
    d.hreq   = 1'b0;
    d.nreq   = 1'b0;
    d.creq   = 1'b0;
    d.cpy    = 1'b0;
    d.rcl    = 1'b0;
    d.blk    = 1'b0;
    d.por    = 1'b0;
    case (q.lst)
      L_IDLE: begin
        if (fall) begin
          d.lst = L_SLOT;
          d.cnt = '0;
          d.drv = tx & ~txbit;
        end
      end
      L_SLOT: begin
        d.cnt = q.cnt + 1'b1;
        if (q.drv && q.cnt == RDH_CYC) begin
          d.drv = 1'b0;
        end
        if (q.cnt == SMP_CYC) begin
          evt = 1'b1;
        end
        if (q.cnt == RST_CYC) begin
          d.lst   = L_RST;
          d.drv   = 1'b0;
          d.phase = P_ROMCMD;
          d.idx   = '0;
        end else if (q.s2 && !q.drv && q.cnt > SMP_CYC) begin
          d.lst = L_IDLE;
        end
      end
      L_RST: begin
        if (q.s2) begin
          d.lst = L_PWAIT;
          d.cnt = '0;
        end
      end
      L_PWAIT: begin
        d.cnt = q.cnt + 1'b1;
        if (q.cnt == PDH_CYC) begin
          d.lst = L_PLOW;
          d.cnt = '0;
          d.drv = 1'b1;
        end
      end
      L_PLOW: begin
        d.cnt = q.cnt + 1'b1;
        if (q.cnt == PDL_CYC) begin
          d.lst = L_IDLE;
          d.drv = 1'b0;
        end
      end
      default: d.lst = L_IDLE;
    endcase

    // --------------------------------------------------------------
    // Protocol, one step per slot at the sample point
    // --------------------------------------------------------------
    if (evt) begin
      d.idx = q.idx + 8'h01;
      if (!tx) begin
        d.sh = nsh;
      end
      case (q.phase)
        P_ROMCMD: begin
          if (bdone) begin
            d.idx = '0;
            if (nsh == NET_READ) begin
              d.phase = P_ROMRD;
            end else if (nsh == NET_MATCH) begin
              d.phase = P_MATCH;
            end else if (nsh == NET_SKIP) begin
              d.phase = P_FCMD;
            end else begin
              d.phase = P_WAITRST;
            end
          end
        end
        P_MATCH: begin
          if (q.s2 != UNIQUE_ID[q.idx[5:0]]) begin
            d.phase = P_WAITRST;
          end else if (q.idx == LAST_ID_BIT) begin
            d.phase = P_FCMD;
            d.idx   = '0;
          end
        end
        P_ROMRD: begin
          if (q.idx == LAST_ID_BIT) begin
            d.phase = P_FCMD;
            d.idx   = '0;
          end
        end
        P_FCMD: begin
          if (bdone) begin
            d.idx   = '0;
            d.cmd   = nsh;
            d.phase = P_WAITRST;
            // Any other command breaks the challenge and lock sequences
            d.chal_ok = 1'b0;
            if (nsh != CMD_BLK_LOCK) begin
              d.armed = 1'b0;
            end
            if (nsh == CMD_WR_CHAL) begin
              d.phase = P_CHAL;
            end else if ((nsh == CMD_HASH_NOID || nsh == CMD_HASH_ID) && q.chal_ok) begin
              d.hreq   = 1'b1;
              d.use_id = (nsh == CMD_HASH_ID);
              d.phase  = P_MACRD;
            end else if (nsh == CMD_CLR_SEC && !q.lock) begin
              d.creq = 1'b1;
            end else if ((nsh == CMD_NXT_NOID || nsh == CMD_NXT_ID) && q.chal_ok && !q.lock) begin
              d.nreq   = 1'b1;
              d.use_id = (nsh == CMD_NXT_ID);
            end else if (nsh == CMD_LOCK_SEC) begin
              d.lock = 1'b1;
            end else if (nsh == CMD_READ || nsh == CMD_WRITE || nsh == CMD_COPY ||
                         nsh == CMD_RECALL || nsh == CMD_BLK_LOCK) begin
              d.phase = P_ADDR;
            end else if (nsh == CMD_SOFT_POR) begin
              d.por = 1'b1;
            end
          end
        end
        P_ADDR: begin
          if (bdone) begin
            d.idx   = '0;
            d.addr  = nsh;
            d.baddr = nsh;
            d.phase = P_WAITRST;
            if (q.cmd == CMD_READ) begin
              d.phase = P_RDDATA;
            end else if (q.cmd == CMD_WRITE) begin
              d.phase = P_WRDATA;
            end else if (q.cmd == CMD_COPY) begin
              d.cpy = 1'b1;
            end else if (q.cmd == CMD_RECALL) begin
              d.rcl = 1'b1;
            end else if (q.cmd == CMD_BLK_LOCK) begin
              d.blk   = q.armed;
              d.armed = 1'b0;
            end
          end
        end
        P_RDDATA: begin
          if (bdone) begin
            d.addr = q.addr + 8'h01;
          end
        end
        P_WRDATA: begin
          if (bdone) begin
            // Only whole bytes reach memory
            d.we    = 1'b1;
            d.waddr = q.addr;
            d.wdata = nsh;
            d.addr  = q.addr + 8'h01;
            d.armed = (q.addr == LOCK_CTRL_ADDR) && nsh[LOCK_EN_BIT];
          end
        end
        P_CHAL: begin
          d.chal = {q.s2, q.chal[63:1]};
          if (q.idx == LAST_ID_BIT) begin
            d.chal_ok = 1'b1;
            d.phase   = P_WAITRST;
          end
        end
        P_MACRD: begin
          if (q.idx == LAST_HASH_BIT) begin
            d.phase = P_WAITRST;
          end
        end
        default: d.phase = P_WAITRST;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q       <= '0;
      q.s1    <= 1'b1;
      q.s2    <= 1'b1;
      q.prv   <= 1'b1;
      q.lst   <= L_IDLE;
      q.phase <= P_WAITRST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign dq_o            = 1'b0;
  assign dq_oe           = q.drv;
  assign mem_raddr       = q.addr;
  assign mem_waddr       = q.waddr;
  assign mem_wdata       = q.wdata;
  assign mem_we          = q.we;
  assign challenge       = q.chal;
  assign hash_req        = q.hreq;
  assign hash_use_id     = q.use_id;
  assign secret_next_req = q.nreq;
  assign secret_clear    = q.creq;
  assign secret_locked   = q.lock;
  assign blk_copy_req    = q.cpy;
  assign blk_recall_req  = q.rcl;
  assign blk_lock_req    = q.blk;
  assign blk_addr        = q.baddr;
  assign soft_por_req    = q.por;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_hash_chal;
    @(posedge clk) disable iff (!arst_n) $rose(hash_req) |-> $past(q.chal_ok);
  endproperty
  a_hash_chal: assert property (p_hash_chal) else $error("hash without challenge");
  property p_clr_lock;
    @(posedge clk) disable iff (!arst_n) secret_locked |-> !secret_clear;
  endproperty
  a_clr_lock: assert property (p_clr_lock) else $error("clear while locked");
  property p_nxt_lock;
    @(posedge clk) disable iff (!arst_n) secret_next_req |-> !secret_locked && $past(q.chal_ok);
  endproperty
  a_nxt_lock: assert property (p_nxt_lock) else $error("bad next secret");
  property p_blk_armed;
    @(posedge clk) disable iff (!arst_n) blk_lock_req |-> $past(q.armed) && !q.armed;
  endproperty
  a_blk_armed: assert property (p_blk_armed) else $error("unarmed block lock");
  property p_wrap;
    @(posedge clk) disable iff (!arst_n) mem_we |-> mem_raddr == 8'(mem_waddr + 8'h01);
  endproperty
  a_wrap: assert property (p_wrap) else $error("write address step");
  property p_pres;
    @(posedge clk) disable iff (!arst_n)
      (q.lst == L_PWAIT && q.cnt == PDH_CYC) |=> dq_oe && q.lst == L_PLOW;
  endproperty
  a_pres: assert property (p_pres) else $error("no presence pulse");
  property p_abort;
    @(posedge clk) disable iff (!arst_n)
      (q.lst == L_SLOT && q.cnt == RST_CYC) |=> q.lst == L_RST && q.phase == P_ROMCMD && !dq_oe;
  endproperty
  a_abort: assert property (p_abort) else $error("long low not a reset");
  property p_chal_smp;
    @(posedge clk) disable iff (!arst_n)
      (q.lst == L_SLOT && q.cnt == SMP_CYC && q.phase == P_CHAL) |=> q.chal[63] == $past(q.s2);
  endproperty
  a_chal_smp: assert property (p_chal_smp) else $error("sample lost");
  property p_release;
    @(posedge clk) disable iff (!arst_n) (dq_oe && q.lst == L_SLOT) |-> q.cnt <= RDH_CYC + 1'b1;
  endproperty
  a_release: assert property (p_release) else $error("read slot not released");
  property p_match;
    @(posedge clk) disable iff (!arst_n)
      (evt && q.phase == P_MATCH && q.s2 != UNIQUE_ID[q.idx[5:0]]) |=> q.phase == P_WAITRST;
  endproperty
  a_match: assert property (p_match) else $error("mismatch answered");
  c_pres:  cover property (@(posedge clk) disable iff (!arst_n) q.lst == L_PLOW ##1 q.lst == L_IDLE);
  c_hash:  cover property (@(posedge clk) disable iff (!arst_n) hash_req);
  c_write: cover property (@(posedge clk) disable iff (!arst_n) mem_we);
  c_block: cover property (@(posedge clk) disable iff (!arst_n) blk_lock_req);
endmodule : swa_slave
`default_nettype wire

// ### test/swa_master_model.sv
// Single-wire bus master with line pullup, behavioural, for the slave bench.
// Assumes a 125 MHz clock; the slave pulls low while dq_oe is high and dq_o low.
`timescale 1ns/10ps
`default_nettype none
module swa_master_model #(
  parameter int RST_LOW = 220
) (
  input  wire logic clk,
  input  wire logic dq_o,
  input  wire logic dq_oe,
  output logic      dq_line
);
  // ----------------------------------------------------------------
  // Slot timing, cycles of 8 ns
  // ----------------------------------------------------------------
  localparam int LOW_MIN = 126;  // 1 us plus margin
  localparam int W1_LOW  = 8;
  localparam int SLOT    = 40;
  localparam int RD_SLOT = 160;
  localparam int RDV     = 132;
  logic pull_q = 1'b0;
  // Released line goes to the pullup level
  assign dq_line = !(pull_q || (dq_oe && !dq_o));

  task automatic bus_reset(output int dly, output int wid);
    dly = 0;
    wid = 0;
    @(posedge clk) pull_q <= 1'b1;
    repeat (RST_LOW) @(posedge clk);
    pull_q <= 1'b0;
    #2;
    while (!dq_oe && dly < 400) begin
      @(posedge clk);
      #2 dly++;
    end
    while (dq_oe && wid < 400) begin
      @(posedge clk);
      #2 wid++;
    end
    repeat (LOW_MIN) @(posedge clk);
  endtask : bus_reset

  // Write slot: short low for a one, whole slot low for a zero
  task automatic xfer(input logic wb);
    @(posedge clk) pull_q <= 1'b1;
    repeat (wb ? W1_LOW : SLOT) @(posedge clk);
    pull_q <= 1'b0;
    if (wb) begin
      repeat (SLOT - W1_LOW) @(posedge clk);
    end
    repeat (LOW_MIN) @(posedge clk);
  endtask : xfer

  // Read slot: 1 us low keeps the slave's zero inside our sample point
  task automatic rslot(output logic rb);
    @(posedge clk) pull_q <= 1'b1;
    repeat (LOW_MIN) @(posedge clk);
    pull_q <= 1'b0;
    repeat (RDV - LOW_MIN) @(posedge clk);
    #2 rb = dq_line;
    repeat (RD_SLOT - RDV) @(posedge clk);
    repeat (LOW_MIN) @(posedge clk);
  endtask : rslot

  task automatic wbyte(input logic [7:0] v);
    for (int i = 0; i < 8; i++) xfer(v[i]);
  endtask : wbyte

  task automatic rbyte(output logic [7:0] v);
    for (int i = 0; i < 8; i++) rslot(v[i]);
  endtask : rbyte
endmodule : swa_master_model
`default_nettype wire

// ### test/swa_slave_tb_top.sv
// Self-checking bench of the single-wire slave with a master model.
// Assumes shortened pulse counts; memory and hash core are modelled here.
`timescale 1ns/10ps
`default_nettype none
module swa_slave_tb_top;
  import swa_pkg::*;
  localparam swa_cnt_t    T_PDH  = 17'h0014;
  localparam swa_cnt_t    T_PDL  = 17'h0028;
  localparam logic [63:0] CHAL   = 64'h8421_7F3C_19E5_60AB;
  logic         clk;
  logic         arst_n;
  wire logic    dq_line;
  logic         dq_o;
  logic         dq_oe;
  logic [7:0]   mem [256];
  logic [7:0]   mem_raddr, mem_waddr, mem_wdata, mem_rdata, blk_addr;
  logic         mem_we, hash_req, hash_use_id, secret_clear, secret_locked;
  logic         blk_copy_req, blk_recall_req, blk_lock_req, use_seen;
  logic         secret_next_req, soft_por_req;
  logic [63:0]  challenge;
  logic [159:0] hash_val;
  int           n_we, n_hash, n_clr, n_cpy, n_rcl, n_lck, n_nxt, n_por, cycles, fail_count, checks;

  swa_slave #(.RST_CYC(17'h00C8), .PDH_CYC(T_PDH), .PDL_CYC(T_PDL),
    .SMP_CYC(17'h0018), .RDH_CYC(17'h0096)) u_swa_slave (
    .clk(clk), .arst_n(arst_n), .dq_i(dq_line), .dq_o(dq_o), .dq_oe(dq_oe),
    .mem_raddr(mem_raddr), .mem_rdata(mem_rdata), .mem_waddr(mem_waddr),
    .mem_wdata(mem_wdata), .mem_we(mem_we), .challenge(challenge), .hash_req(hash_req),
    .hash_use_id(hash_use_id), .hash_result(hash_val), .secret_next_req(secret_next_req),
    .secret_clear(secret_clear), .secret_locked(secret_locked), .blk_copy_req(blk_copy_req),
    .blk_recall_req(blk_recall_req), .blk_lock_req(blk_lock_req), .blk_addr(blk_addr),
    .soft_por_req(soft_por_req)
  );
  swa_master_model u_swa_master (.clk(clk), .dq_o(dq_o), .dq_oe(dq_oe), .dq_line(dq_line));

  // ----------------------------------------------------------------
  // Memory, pulse counters, timeout
  // ----------------------------------------------------------------
  assign mem_rdata = mem[mem_raddr];
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    if (mem_we) begin
      mem[mem_waddr] <= mem_wdata;
      n_we++;
    end
    if (hash_req) begin
      n_hash++;
      use_seen = hash_use_id;
      // Hash core stand-in: identifier field all ones when left out
      hash_val <= {challenge, 32'hC3A5_0F1E, hash_use_id ? UID_DEFAULT : 64'hFFFF_FFFF_FFFF_FFFF};
    end
    n_clr += secret_clear;
    n_nxt += secret_next_req;
    n_por += soft_por_req;
    n_cpy += blk_copy_req;
    n_rcl += blk_recall_req;
    n_lck += blk_lock_req;
    // Above the roughly 91k cycles the scenarios need
    if (++cycles == 100000) begin
      fail_count++;
      complete_run();
    end
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic start(input logic [7:0] fcmd);
    int d, w;
    u_swa_master.bus_reset(d, w);
    u_swa_master.wbyte(NET_SKIP);
    u_swa_master.wbyte(fcmd);
  endtask : start

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_presence;
    int d, w;
    u_swa_master.bus_reset(d, w);
    check(d >= T_PDH + 1 && d <= T_PDH + 6, 1);
    check(w, T_PDL + 1);
  endtask : t_presence

  task automatic t_write;
    int d, w;
    start(CMD_WRITE);
    u_swa_master.wbyte(8'hFE);
    for (int i = 0; i < 3; i++) u_swa_master.wbyte(8'hA1 + 8'(i));
    // Half a byte, then a long low: nothing may be stored
    for (int i = 0; i < 4; i++) u_swa_master.xfer(1'b0);
    u_swa_master.bus_reset(d, w);
    check(n_we, 3);
    check(mem[8'hFE], 8'hA1);
    check(mem[8'h00], 8'hA3);
    check(mem[8'h01], 8'h5B);
  endtask : t_write

  task automatic t_read;
    logic [7:0] b;
    start(CMD_READ);
    u_swa_master.wbyte(8'hFF);
    u_swa_master.rbyte(b);
    check(b, 8'hA2);
    u_swa_master.rbyte(b);
    check(b, 8'hA3);
  endtask : t_read

  task automatic t_match;
    int d, w;
    logic [63:0] bad;
    // Only the very last bit differs
    bad = UID_DEFAULT ^ 64'h8000_0000_0000_0000;
    u_swa_master.bus_reset(d, w);
    u_swa_master.wbyte(NET_MATCH);
    for (int i = 0; i < 8; i++) u_swa_master.wbyte(bad[8*i +: 8]);
    u_swa_master.wbyte(CMD_CLR_SEC);
    check(n_clr, 0);
  endtask : t_match

  task automatic t_hash;
    logic [7:0] b;
    start(CMD_WR_CHAL);
    for (int i = 0; i < 8; i++) u_swa_master.wbyte(CHAL[8*i +: 8]);
    check(challenge, CHAL);
    start(CMD_HASH_ID);
    check(n_hash, 1);
    check(use_seen, 1'b1);
    u_swa_master.rbyte(b);
    check(b, UID_DEFAULT[7:0]);
    start(CMD_HASH_NOID);
    check(n_hash, 1);
  endtask : t_hash

  task automatic t_secret;
    start(CMD_CLR_SEC);
    check(n_clr, 1);
    start(CMD_LOCK_SEC);
    check(secret_locked, 1'b1);
    start(CMD_CLR_SEC);
    check(n_clr, 1);
    start(CMD_NXT_ID);
    check({n_nxt, n_por}, 64'h0);
  endtask : t_secret

  task automatic t_block;
    start(CMD_COPY);
    u_swa_master.wbyte(8'h23);
    check({n_cpy, 24'h0, blk_addr}, {32'h1, 24'h0, 8'h23});
    start(CMD_RECALL);
    u_swa_master.wbyte(8'h47);
    check({n_rcl, 24'h0, blk_addr}, {32'h1, 24'h0, 8'h47});
    start(CMD_BLK_LOCK);
    u_swa_master.wbyte(8'h10);
    check(n_lck, 0);
    start(CMD_WRITE);
    u_swa_master.wbyte(LOCK_CTRL_ADDR);
    u_swa_master.wbyte(8'h40);
    start(CMD_BLK_LOCK);
    u_swa_master.wbyte(8'h12);
    check({n_lck, 24'h0, blk_addr}, {32'h1, 24'h0, 8'h12});
  endtask : t_block

  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5A;
    arst_n = 1'b0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    t_presence();
    t_write();
    t_read();
    t_match();
    t_hash();
    t_secret();
    t_block();
    complete_run();
  end
endmodule : swa_slave_tb_top
`default_nettype wire
